/* File: core/ucip_input_port.sv */
// Host control port, sample registers, serial links and demand strobe.
// Assumes host pins are asynchronous to mclk_in and each serial link runs
// on its own bit clock; the data bus tristate is resolved outside.
`timescale 1ns/1ps
module ucip_input_port
  import ucip_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic [5:0]            regsel_lines_in,
  input  wire logic                  unit_select_n_in,
  input  wire logic                  output_enable_n_in,
  input  wire logic                  store_strobe_n_in,
  input  wire logic [7:0]            host_data_in,
  output logic      [7:0]            host_data_out,
  output logic                       host_data_oe_out,
  input  wire logic [UCIP_NCH-1:0]   serial_bit_clock_in,
  input  wire logic [UCIP_NCH-1:0]   serial_frame_sync_in,
  input  wire logic [UCIP_NCH-1:0]   serial_data_line_in,
  output logic                       sample_demand_strobe_out,
  output ucip_sample_s [UCIP_NCH-1:0] sample_out,
  output logic                       sample_valid_out
);

  logic [7:0]   regs_q [UCIP_NREGS];
  ucip_host_s   host_pins;
  ucip_host_s   host_m_q;
  ucip_host_s   host_s_q;
  ucip_host_s   host_p_q;
  logic         wr_now;
  logic         wr_prev;
  logic         write_end;
  logic [7:0]   status;
  logic [7:0]   inctrl;
  logic [14:0]  n_raw;
  logic [14:0]  n_eff;
  logic [16:0]  period;
  logic [16:0]  width;
  logic [16:0]  req_cnt_q;
  logic         req_act;
  logic         req_start;
  logic         rst_hold_q;
  logic [3:0]   ser_seen_q;
  logic         host_seen_q;
  logic [3:0]   tog_m_q;
  logic [3:0]   tog_s_q;
  logic [3:0]   tog_p_q;
  logic [3:0]   ser_new;
  logic [3:0]   half_q_q;
  ucip_sample_s asm_q [UCIP_NCH];
  logic [31:0]  word_l [UCIP_NCH];
  logic [3:0]   tog_l;

  assign inctrl = regs_q[UCIP_INCTRL_ADDR];
  assign n_raw  = {regs_q[UCIP_NHI_ADDR][6:0], regs_q[UCIP_NLO_ADDR]};
  assign n_eff  = (n_raw < UCIP_N_MIN) ? UCIP_N_MIN : n_raw;

  // Host pins pass two flops before anything looks at them.
  assign host_pins = '{addr: regsel_lines_in, data: host_data_in,
                       sel_n: unit_select_n_in, oen_n: output_enable_n_in,
                       str_n: store_strobe_n_in};

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      host_m_q <= '{addr: 6'h00, data: 8'h00, sel_n: 1'b1, oen_n: 1'b1,
                    str_n: 1'b1};
      host_s_q <= '{addr: 6'h00, data: 8'h00, sel_n: 1'b1, oen_n: 1'b1,
                    str_n: 1'b1};
      host_p_q <= '{addr: 6'h00, data: 8'h00, sel_n: 1'b1, oen_n: 1'b1,
                    str_n: 1'b1};
    end else begin
      host_m_q <= host_pins;
      host_s_q <= host_m_q;
      host_p_q <= host_s_q;
    end
  end

  // A write is open while select and strobe are both low; it closes on
  // whichever of the two rises first. In the alternate mode the strobe
  // is a level direction select and select alone opens and closes it.
  assign wr_now    = !host_s_q.sel_n && !host_s_q.str_n;
  assign wr_prev   = !host_p_q.sel_n && !host_p_q.str_n;
  assign write_end = wr_prev && !wr_now;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      for (int r = 0; r < UCIP_NREGS; r++) begin
        regs_q[r] <= 8'h00;
      end
      regs_q[UCIP_INCTRL_ADDR] <= UCIP_INCTRL_RST;
      regs_q[UCIP_NLO_ADDR]    <= UCIP_NLO_RST;
      regs_q[UCIP_NHI_ADDR]    <= UCIP_NHI_RST;
    end else if (write_end && host_p_q.addr != UCIP_STATUS_ADDR) begin
      // Data from the cycle before the close is safely inside hold time.
      regs_q[host_p_q.addr] <= host_p_q.data;
    end
  end

  // Status is read-only: bits 3..0 flag serial words and bit 4 a mapped
  // byte, each since the last demand; bit 5 shows the demand window.
  assign status = {2'b00, req_act, host_seen_q, ser_seen_q};

  // The bus is driven only when select and enable are low and the strobe
  // is high; the read value follows the synchronised address.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      host_data_oe_out <= 1'b0;
      host_data_out    <= 8'h00;
    end else begin
      host_data_oe_out <= !host_s_q.sel_n && !host_s_q.oen_n &&
                          host_s_q.str_n;
      host_data_out    <= (host_s_q.addr == UCIP_STATUS_ADDR) ?
                          status : regs_q[host_s_q.addr];
    end
  end

  // Demand strobe timebase.
  assign period = inctrl[UCIP_BIT_COMPLEX] ? {n_eff, 2'b00}
                                           : {1'b0, n_eff, 1'b0};
  assign width  = inctrl[UCIP_BIT_REQ_WIDE] ? {3'b000, n_eff[14:1]}
                                            : UCIP_REQ_NARROW;
  assign req_act   = req_cnt_q < width;
  assign req_start = req_cnt_q == 17'h00000;

  // Reset leaves the count at one, so no demand is issued in the very
  // first cycle out of reset, before any period has been programmed.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      req_cnt_q <= 17'h00001;
    end else if (req_cnt_q >= period - 17'h00001) begin
      req_cnt_q <= 17'h00000;
    end else begin
      req_cnt_q <= req_cnt_q + 17'h00001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sample_demand_strobe_out <= 1'b0;
    end else begin
      sample_demand_strobe_out <= req_act ^ inctrl[UCIP_BIT_REQ_LOW];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rst_hold_q <= 1'b1;
    end else begin
      rst_hold_q <= 1'b0;
    end
  end

  // Serial links, one bit clock domain per channel.
  for (genvar c = 0; c < UCIP_NCH; c++) begin : g_link
    logic        sck;
    logic        fs;
    logic        lrst_m_q;
    logic        lrst_q;
    logic [1:0]  cfg_m_q;
    logic [1:0]  cfg_q;
    logic        fs_prev_q;
    logic [5:0]  cnt_q;
    logic [31:0] sh_q;
    logic [31:0] word_q;
    logic        tog_q;

    // The edge select is a static setting; changing it mid-frame makes a
    // runt clock, so software alters it only while the links are idle.
    assign sck = serial_bit_clock_in[c] ^ inctrl[UCIP_BIT_EDGE_INV];
    assign fs  = serial_frame_sync_in[c] ^ cfg_q[0];

    always_ff @(posedge sck) begin
      lrst_m_q <= rst_hold_q;
      lrst_q   <= lrst_m_q;
      cfg_m_q  <= {inctrl[UCIP_BIT_IQ_JOINT], inctrl[UCIP_BIT_FRAME_INV]};
      cfg_q    <= cfg_m_q;
    end

    // A new frame opens on an inactive to active sync edge, so back to
    // back frames need the sync to drop in between; data follows MSB first.
    always_ff @(posedge sck) begin
      if (lrst_q) begin
        fs_prev_q <= 1'b0;
        cnt_q     <= 6'h00;
        sh_q      <= 32'h00000000;
        word_q    <= 32'h00000000;
        tog_q     <= 1'b0;
      end else begin
        fs_prev_q <= fs;
        if (fs && !fs_prev_q) begin
          cnt_q <= cfg_q[1] ? UCIP_LEN_JOINT : UCIP_LEN_SHORT;
        end else if (cnt_q != 6'h00) begin
          sh_q  <= {sh_q[30:0], serial_data_line_in[c]};
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h01) begin
            word_q <= {sh_q[30:0], serial_data_line_in[c]};
            tog_q  <= ~tog_q;
          end
        end
      end
    end

    assign word_l[c] = word_q;
    assign tog_l[c]  = tog_q;

    AST_FRAME_LEN: assert property (@(posedge sck) disable iff (lrst_q)
      (fs && !fs_prev_q) |=> (cnt_q == ($past(cfg_q[1]) ? UCIP_LEN_JOINT
                                                        : UCIP_LEN_SHORT)))
      else $error("Frame length not loaded on sync edge.");
  end

  // Each finished word flips a toggle; the word itself stays put for at
  // least sixteen bit clocks, so it is read once the toggle has crossed.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      tog_m_q <= 4'h0;
      tog_s_q <= 4'h0;
      tog_p_q <= 4'h0;
    end else begin
      tog_m_q <= tog_l;
      tog_s_q <= tog_m_q;
      tog_p_q <= tog_s_q;
    end
  end
  assign ser_new = tog_s_q ^ tog_p_q;

  // Words are assembled whenever they land, so a frame that began a few
  // bit clocks ahead of the strobe still counts for the coming period.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      half_q_q <= 4'h0;
      for (int c = 0; c < UCIP_NCH; c++) begin
        asm_q[c] <= '{i: 16'h0000, q: 16'h0000};
      end
    end else begin
      for (int c = 0; c < UCIP_NCH; c++) begin
        if (!inctrl[UCIP_BIT_COMPLEX] || inctrl[UCIP_BIT_IQ_JOINT]) begin
          half_q_q[c] <= 1'b0;
        end
        if (ser_new[c]) begin
          if (inctrl[UCIP_BIT_IQ_JOINT]) begin
            asm_q[c].i <= word_l[c][31:16];
            asm_q[c].q <= word_l[c][15:0];
          end else if (inctrl[UCIP_BIT_COMPLEX] && half_q_q[c]) begin
            asm_q[c].q  <= word_l[c][15:0];
            half_q_q[c] <= 1'b0;
          end else begin
            asm_q[c].i  <= word_l[c][15:0];
            half_q_q[c] <= inctrl[UCIP_BIT_COMPLEX];
          end
        end
      end
    end
  end

  // Arrival flags for software; an arrival in the strobe cycle survives.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ser_seen_q  <= 4'h0;
      host_seen_q <= 1'b0;
    end else begin
      ser_seen_q  <= (req_start ? 4'h0 : ser_seen_q) | ser_new;
      host_seen_q <= (req_start ? 1'b0 : host_seen_q) |
                     (write_end && host_p_q.addr >= UCIP_SAMPLE_BASE &&
                      host_p_q.addr <= UCIP_SAMPLE_LAST);
    end
  end

  // At each demand the channel datapath takes one sample per channel,
  // from the serial links or from the mapped byte registers. Channel c
  // owns bytes base+4c (Q low) up to base+4c+3 (I high).
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sample_valid_out <= 1'b0;
      for (int c = 0; c < UCIP_NCH; c++) begin
        sample_out[c] <= '{i: 16'h0000, q: 16'h0000};
      end
    end else begin
      sample_valid_out <= req_start;
      for (int c = 0; c < UCIP_NCH; c++) begin
        if (req_start && inctrl[UCIP_BIT_HOST_SRC]) begin
          sample_out[c].i <= {regs_q[UCIP_SAMPLE_BASE + 6'(4*c + 3)],
                              regs_q[UCIP_SAMPLE_BASE + 6'(4*c + 2)]};
          sample_out[c].q <= {regs_q[UCIP_SAMPLE_BASE + 6'(4*c + 1)],
                              regs_q[UCIP_SAMPLE_BASE + 6'(4*c)]};
        end else if (req_start) begin
          sample_out[c] <= asm_q[c];
        end
      end
    end
  end

  AST_WRITE_CAPTURE: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    (write_end && host_p_q.addr != UCIP_STATUS_ADDR) |=>
      regs_q[$past(host_p_q.addr)] == $past(host_p_q.data))
    else $error("Write data not stored at close of write.");

  AST_BUS_DRIVE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    host_data_oe_out |-> $past(!host_s_q.sel_n && !host_s_q.oen_n &&
                               host_s_q.str_n))
    else $error("Data bus driven outside a read.");

  AST_READ_DATA: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (host_s_q.addr != UCIP_STATUS_ADDR) |=>
      host_data_out == $past(regs_q[host_s_q.addr]))
    else $error("Read data does not match register.");

  AST_REQ_PERIOD: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    (req_start && $stable(period)) |-> $past(req_cnt_q) >= $past(period)
                                        - 17'h00001)
    else $error("Demand period restarted early.");

  AST_REQ_NARROW: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    (req_start && !inctrl[UCIP_BIT_REQ_WIDE] && $stable(inctrl)) ##1
    $stable(inctrl) ##1 $stable(inctrl) |->
      $past(req_act, 2) && $past(req_act) && !req_act)
    else $error("Narrow demand strobe not two cycles.");

  AST_REQ_PIN: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (req_start && $stable(inctrl)) |=>
      sample_demand_strobe_out == !$past(inctrl[UCIP_BIT_REQ_LOW]) ##1
      sample_valid_out == 1'b0)
    else $error("Demand pin level wrong at period start.");

  AST_HANDOFF: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (req_start && !inctrl[UCIP_BIT_HOST_SRC]) |=>
      sample_valid_out && sample_out[0] == $past(asm_q[0]))
    else $error("Serial sample not handed over at demand.");

  AST_HOST_SAMPLE: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    (req_start && inctrl[UCIP_BIT_HOST_SRC]) |=>
      sample_out[0].i == $past({regs_q[UCIP_SAMPLE_BASE + 6'h03],
                                regs_q[UCIP_SAMPLE_BASE + 6'h02]}))
    else $error("Mapped sample not handed over.");

  AST_JOINT_SPLIT: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    (ser_new[0] && inctrl[UCIP_BIT_IQ_JOINT]) |=>
      asm_q[0].i == $past(word_l[0][31:16]) &&
      asm_q[0].q == $past(word_l[0][15:0]))
    else $error("Joint word split wrongly.");

  AST_SEEN_SET: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    ser_new[1] |=> ser_seen_q[1])
    else $error("Arrival flag lost.");

  // A low store strobe means a write is under way, so the bus stays off.
  AST_OE_WRITE: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    !host_s_q.str_n |=> !host_data_oe_out)
    else $error("Data bus driven during a write.");

  // Between demands the channel datapath must see a steady sample.
  AST_SAMPLE_HOLD: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    !req_start |=> sample_out == $past(sample_out) && !sample_valid_out)
    else $error("Sample changed between demands.");

  // In two-word complex mode the second word of a pair lands in Q and
  // the pointer goes back to I for the next pair.
  AST_HALF_ORDER: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    (ser_new[1] && half_q_q[1] && inctrl[UCIP_BIT_COMPLEX] &&
     !inctrl[UCIP_BIT_IQ_JOINT]) |=>
      asm_q[1].q == $past(word_l[1][15:0]) && !half_q_q[1])
    else $error("Quadrature word not stored after in-phase.");

  AST_HOST_SEEN: assert property (@(posedge mclk_in)
    disable iff (sys_rst_in)
    (write_end && host_p_q.addr >= UCIP_SAMPLE_BASE &&
     host_p_q.addr <= UCIP_SAMPLE_LAST) |=> host_seen_q)
    else $error("Mapped byte arrival not flagged.");

endmodule

/* File: core/ucip_pkg.sv */
// Constants, field layouts and carrier types of the up-converter input port.
// Assumes one core clock domain plus four free-standing serial link clocks.
package ucip_pkg;
  localparam int UCIP_ADDR_W  = 6;
  localparam int UCIP_DATA_W  = 8;
  localparam int UCIP_NREGS   = 64;
  localparam int UCIP_NCH     = 4;
  localparam int UCIP_SMP_W   = 16;
  localparam int UCIP_CNT_W   = 17;

  localparam logic [5:0] UCIP_SAMPLE_BASE = 6'h10;
  localparam logic [5:0] UCIP_SAMPLE_LAST = 6'h1f;
  localparam logic [5:0] UCIP_STATUS_ADDR = 6'h0b;
  localparam logic [5:0] UCIP_INCTRL_ADDR = 6'h0c;
  localparam logic [5:0] UCIP_NLO_ADDR    = 6'h0d;
  localparam logic [5:0] UCIP_NHI_ADDR    = 6'h0e;

  localparam int UCIP_BIT_EDGE_INV  = 0;
  localparam int UCIP_BIT_FRAME_INV = 1;
  localparam int UCIP_BIT_IQ_JOINT  = 2;
  localparam int UCIP_BIT_COMPLEX   = 3;
  localparam int UCIP_BIT_REQ_WIDE  = 4;
  localparam int UCIP_BIT_REQ_LOW   = 5;
  localparam int UCIP_BIT_HOST_SRC  = 6;
  localparam int UCIP_BIT_HOST_WR   = 4;
  localparam int UCIP_BIT_REQ_LVL   = 5;

  localparam logic [7:0]  UCIP_INCTRL_RST = 8'h00;
  localparam logic [7:0]  UCIP_NLO_RST    = 8'h08;
  localparam logic [7:0]  UCIP_NHI_RST    = 8'h00;
  localparam logic [14:0] UCIP_N_MIN      = 15'h0008;
  localparam logic [16:0] UCIP_REQ_NARROW = 17'h00002;
  localparam logic [5:0]  UCIP_LEN_SHORT  = 6'h10;
  localparam logic [5:0]  UCIP_LEN_JOINT  = 6'h20;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } ucip_sample_s;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
    logic       sel_n;
    logic       oen_n;
    logic       str_n;
  } ucip_host_s;
endpackage

/* File: tb/ucip_serial_model.sv */
// Far-end sender model: four bit-serial links, each with its own bit clock.
// Assumes the bench calls its tasks; clocks stand still between task calls.
`timescale 1ns/1ps
module ucip_serial_model (
  output logic [3:0] sck_out,
  output logic [3:0] sfs_out,
  output logic [3:0] sdi_out
);
  logic edge_inv;
  logic frame_inv;

  initial begin
    edge_inv = 1'b0;
    frame_inv = 1'b0;
    sck_out = 4'h0;
    sfs_out = 4'h0;
    sdi_out = 4'h0;
  end

  task automatic set_pol(input logic e, input logic f);
    edge_inv = e;
    frame_inv = f;
    sck_out = {4{e}};
    sfs_out = {4{f}};
  endtask

  // Lines change half a period before the edge the device samples on.
  task automatic bit_cyc(input int ch, input logic s, input logic d);
    sfs_out[ch] = s ^ frame_inv;
    sdi_out[ch] = d;
    #16;
    sck_out[ch] = ~edge_inv;
    #16;
    sck_out[ch] = edge_inv;
  endtask

  task automatic ticks(input int n);
    for (int k = 0; k < n; k++) begin
      #16 sck_out = ~{4{edge_inv}};
      #16 sck_out = {4{edge_inv}};
    end
  endtask

  task automatic send(input int ch, input logic [31:0] w, input int nbits);
    bit_cyc(ch, 1'b0, ~sdi_out[ch]);
    bit_cyc(ch, 1'b1, ~sdi_out[ch]);
    for (int b = nbits - 1; b >= 0; b--) begin
      bit_cyc(ch, 1'b0, w[b]);
    end
    bit_cyc(ch, 1'b0, ~w[0]);
    sdi_out[ch] = w[0];
  endtask
endmodule

/* File: tb/ucip_input_port_tb.sv */
// Self-checking bench of the input port: host bus, demand strobe, links.
// Assumes the serial model drives the links and the bench resolves the bus.
`timescale 1ns/1ps
`define CHK(a, b) n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end
module ucip_input_port_tb;
  import ucip_pkg::*;
  logic                        mclk;
  logic                        sys_rst;
  logic [5:0]                  addr;
  logic                        sel_n;
  logic                        oen_n;
  logic                        str_n;
  logic                        host_drv;
  logic [7:0]                  wdata;
  logic [7:0]                  float_pat = 8'h00;
  logic [7:0]                  bus_w;
  logic [7:0]                  dout;
  logic                        oe;
  logic [3:0]                  sck;
  logic [3:0]                  serial_frame_sync;
  logic [3:0]                  sdi;
  logic                        demand;
  ucip_sample_s [UCIP_NCH-1:0] smp;
  logic                        valid;
  logic [7:0]                  rd;
  logic [7:0]                  b [16];
  int                          err_total;
  int                          n_checks;

  // A released bus shows a changing pattern, never the last driven value.
  always @(posedge mclk) float_pat <= float_pat + 8'h5b;
  assign bus_w = oe ? dout : (host_drv ? wdata : float_pat);

  ucip_input_port u_dut (
    .mclk_in(mclk), .sys_rst_in(sys_rst), .regsel_lines_in(addr),
    .unit_select_n_in(sel_n), .output_enable_n_in(oen_n),
    .store_strobe_n_in(str_n), .host_data_in(bus_w),
    .host_data_out(dout), .host_data_oe_out(oe),
    .serial_bit_clock_in(sck), .serial_frame_sync_in(serial_frame_sync),
    .serial_data_line_in(sdi), .sample_demand_strobe_out(demand),
    .sample_out(smp), .sample_valid_out(valid)
  );
  ucip_serial_model snd (.sck_out(sck), .sfs_out(serial_frame_sync), .sdi_out(sdi));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic report_and_stop();
    $display("Checks made: %0d, mismatches: %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Alternate mode keeps the enable low, strobe as direction, select timed.
  task automatic host_acc(input logic alt, input logic wr,
                          input logic [5:0] a, input logic [7:0] wd,
                          output logic [7:0] rdv);
    @(negedge mclk);
    addr = a;
    wdata = wd;
    host_drv = wr;
    oen_n = ~alt;
    str_n = ~(alt & wr);
    repeat (4) @(negedge mclk);
    sel_n = 1'b0;
    repeat (4) @(negedge mclk);
    if (!alt) begin
      if (wr) str_n = 1'b0;
      else oen_n = 1'b0;
    end
    repeat (5) @(negedge mclk);
    if (wr) begin
      `CHK(oe, 1'b0)
    end else begin
      `CHK(oe, 1'b1)
    end
    rdv = bus_w;
    if (!alt) begin
      str_n = 1'b1;
      oen_n = 1'b1;
      repeat (4) @(negedge mclk);
    end
    sel_n = 1'b1;
    repeat (4) @(negedge mclk);
    str_n = 1'b1;
    oen_n = 1'b1;
    host_drv = 1'b0;
    repeat (5) @(negedge mclk);
    `CHK(oe, 1'b0)
  endtask

  task automatic cfg(input logic [14:0] n, input logic [7:0] c);
    logic [7:0] d;
    host_acc(1'b0, 1'b1, UCIP_NLO_ADDR, n[7:0], d);
    host_acc(1'b0, 1'b1, UCIP_NHI_ADDR, {1'b0, n[14:8]}, d);
    host_acc(1'b0, 1'b1, UCIP_INCTRL_ADDR, c, d);
  endtask

  task automatic wait_valid();
    int k;
    k = 0;
    @(negedge mclk);
    while (valid !== 1'b1 && k < 5000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 5000) begin
      err_total++;
      $display("Error at %0t: no sample handed over", $time);
    end
  endtask

  task automatic demand_chk(input int n, input logic cx, wd, lo);
    int neff;
    int per;
    int wid;
    neff = (n < 8) ? 8 : n;
    cfg(15'(n), {2'b00, lo, wd, cx, 3'b000});
    wait_valid();
    wait_valid();
    per = 0;
    wid = 0;
    do begin
      if (demand === ~lo) wid++;
      per++;
      @(negedge mclk);
    end while (valid !== 1'b1 && per < 1000);
    `CHK(per, neff * (cx ? 4 : 2))
    `CHK(wid, wd ? neff / 2 : 2)
  endtask

  initial begin
    #600000;
    err_total++;
    $display("Error at %0t: run did not finish", $time);
    report_and_stop();
  end

  initial begin
    int ch;
    int ty;
    logic [1:0] pol;
    logic [31:0] w;
    logic [31:0] w2;
    logic [7:0] v;
    logic [15:0] ei;
    logic [15:0] eq;
    err_total = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    addr = 6'h00;
    sel_n = 1'b1;
    oen_n = 1'b1;
    str_n = 1'b1;
    host_drv = 1'b0;
    wdata = 8'h00;
    void'($urandom(32'h5e56));
    snd.ticks(4);
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    for (int a = 0; a < 64; a++) begin
      if (a != UCIP_STATUS_ADDR) begin
        host_acc(1'b0, 1'b0, 6'(a), 8'h00, rd);
        `CHK(rd, (a == UCIP_NLO_ADDR) ? 8'h08 : 8'h00)
      end
    end
    for (int a = 0; a < 64; a++) begin
      if (a < 11 || a > 14) begin
        v = 8'($urandom());
        host_acc(a[0], 1'b1, 6'(a), v, rd);
        host_acc(~a[0], 1'b0, 6'(a), 8'h00, rd);
        `CHK(rd, v)
      end
    end
    for (int i = 0; i < 8; i++) begin
      demand_chk((i == 0) ? 3 : 8 + 2 * $urandom_range(0, 8),
                 i[0], i[1], i[2]);
    end
    cfg(15'd256, 8'h48);
    wait_valid();
    for (int a = 31; a >= 16; a--) begin
      b[a-16] = 8'($urandom());
      host_acc(1'b0, 1'b1, 6'(a), b[a-16], rd);
    end
    host_acc(1'b0, 1'b0, UCIP_STATUS_ADDR, 8'h00, rd);
    `CHK(rd[4], 1'b1)
    wait_valid();
    for (int c = 0; c < 4; c++) begin
      `CHK(smp[c].q, {b[4*c+1], b[4*c]})
      `CHK(smp[c].i, {b[4*c+3], b[4*c+2]})
    end
    // Types: real 16, complex two words, joint I/Q, real in upper half.
    for (int it = 0; it < 16; it++) begin
      ch = it % 4;
      ty = it / 4;
      pol = 2'((ch + ty) % 4);
      w = $urandom();
      w2 = $urandom();
      // Settings go in before the pins move, and idle ticks let each link
      // leave reset and take the new settings; a stray start seen while
      // they settle is overridden by the real sync edge.
      cfg(15'd64, {4'h0, ty == 1 || ty == 2, ty >= 2, pol[1], pol[0]});
      snd.set_pol(pol[0], pol[1]);
      snd.ticks(4);
      snd.send(ch, w, (ty >= 2) ? 32 : 16);
      if (ty == 1) snd.send(ch, w2, 16);
      repeat (8) @(negedge mclk);
      wait_valid();
      ei = (ty >= 2) ? w[31:16] : w[15:0];
      eq = (ty == 1) ? w2[15:0] : w[15:0];
      `CHK(smp[ch].i, ei)
      if (ty == 1 || ty == 2) begin
        `CHK(smp[ch].q, eq)
      end
    end
    report_and_stop();
  end
endmodule
